//--- dv/adc_list_flow_test.sv
// Purpose: Self-checking bench for adc_list_flow
// Assumes: Tasks are entered just after a rising edge
// Notes: Bus task idles one cycle so no signal is assigned twice at one edge
`timescale 1ns/1ps
`include "adc_flow_consts.svh"
module adc_list_flow_test;
   import adc_flow_pkg::*;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, busy, start_sequence, abort_conversion, halted, csel, rsel;
   logic conversion_irq, abort_done_irq, error_irq, machine_exception;
   logic [7:0] cidx, ridx, starts;
   logic [3:0] len = 4'h3;
   conv_event_s conv_event;
   fault_event_s fault = '0;
   flow_req_s flow = '0;
   int n_fail = 0;
   int check_count = 0;
   adc_list_flow u_dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .conv_event(conv_event), .fault_event(fault), .flow_req(flow),
      .start_sequence(start_sequence), .abort_conversion(abort_conversion), .halted(halted),
      .command_list_select(csel), .result_list_select(rsel), .command_index(cidx),
      .result_index(ridx), .conversion_irq(conversion_irq), .abort_done_irq(abort_done_irq),
      .error_irq(error_irq), .machine_exception(machine_exception));
   conv_engine_model u_eng (.mclk(mclk), .reset_n(reset_n), .start_sequence(start_sequence),
      .abort_conversion(abort_conversion), .list_len(len), .conv_event(conv_event),
      .busy(busy), .starts(starts));
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) n_fail++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, '0);
      chk(nm, exp, rd);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      repeat (8) @(posedge mclk);
      while (busy === 1'b1 && n < 200) begin
         @(posedge mclk);
         n++;
      end
      repeat (4) @(posedge mclk);
   endtask
   task automatic pulse(input fault_event_s f);
      fault <= f;
      @(posedge mclk);
      fault <= '0;
      repeat (3) @(posedge mclk);
   endtask
   task automatic s_regs();
      rd_chk("control", `OFS_CONTROL, 32'h0000_0003);
      rd_chk("unmapped", 12'h100, 32'h0000_0000);
      chk("pslverr", 1'b1, err);
      rd_chk("status", `OFS_STATUS, 32'h0000_0000);
   endtask
   task automatic s_list0();
      bus(1'b1, `OFS_CONV_ENABLE, 32'h0000_FFFF);
      bus(1'b1, `OFS_ERR_ENABLE, 32'h0000_0003);
      bus(1'b1, `OFS_CONTROL, 32'h0000_0007);
      bus(1'b1, `OFS_FLOW, 32'h0000_0004);
      wait_idle();
      rd_chk("conv flags", `OFS_CONV_FLAGS, 32'h0000_000F);
      chk("conv irq", 1'b1, conversion_irq);
      chk("cmd sel", 1'b0, csel);
      bus(1'b1, `OFS_CONV_FLAGS, 32'h0000_FFFF);
      repeat (3) @(posedge mclk);
      chk("conv irq off", 1'b0, conversion_irq);
   endtask
   task automatic s_swap();
      bus(1'b1, `OFS_CONTROL, 32'h0000_001F);
      bus(1'b1, `OFS_FLOW, 32'h0000_000C);
      wait_idle();
      chk("cmd sel one", 1'b1, csel);
      chk("res sel one", 1'b1, rsel);
      rd_chk("eol info", `OFS_EOL_INFO, 32'h0000_0302);
      rd_chk("imd info", `OFS_IMD_INFO, 32'h0000_0302);
      bus(1'b1, `OFS_CONV_FLAGS, 32'h0000_FFFF);
      bus(1'b1, `OFS_FLOW, 32'h0000_0004);
      wait_idle();
      chk("cmd sel kept", 1'b1, csel);
      chk("res sel swapped", 1'b0, rsel);
      bus(1'b1, `OFS_CONV_FLAGS, 32'h0000_FFFF);
      bus(1'b1, `OFS_CONTROL, 32'h0000_0007);
      @(posedge mclk);
      chk("cmd sel single", 1'b0, csel);
      chk("res sel single", 1'b0, rsel);
   endtask
   task automatic s_minor();
      bus(1'b1, `OFS_FLOW, 32'h0000_0008);
      repeat (3) @(posedge mclk);
      rd_chk("load ok err", `OFS_ERR_FLAGS, 32'h0000_0040);
      chk("err irq", 1'b1, error_irq);
      chk("still running", 1'b0, halted);
      bus(1'b1, `OFS_ERR_FLAGS, 32'h0000_0040);
   endtask
   task automatic s_abort();
      len <= 4'h8;
      bus(1'b1, `OFS_FLOW, 32'h0000_0004);
      repeat (8) @(posedge mclk);
      bus(1'b1, `OFS_FLOW, 32'h0000_0001);
      wait_idle();
      rd_chk("abort done", `OFS_ERR_FLAGS, 32'h0000_0100);
      chk("abort irq", 1'b1, abort_done_irq);
      chk("result index", 8'h00, ridx);
      chk("command index", 8'h00, cidx);
      bus(1'b1, `OFS_ERR_FLAGS, 32'h0000_0100);
      bus(1'b1, `OFS_CONV_FLAGS, 32'h0000_FFFF);
   endtask
   task automatic s_severe();
      pulse(4'b1000);
      chk("halted", 1'b1, halted);
      chk("err irq sev", 1'b1, error_irq);
      bus(1'b1, `OFS_ERR_FLAGS, 32'h0000_0001);
      rd_chk("sev sticky", `OFS_ERR_FLAGS, 32'h0000_0001);
      bus(1'b1, `OFS_CONTROL, 32'h0000_0027);
      repeat (3) @(posedge mclk);
      chk("resumed", 1'b0, halted);
      rd_chk("sev cleared", `OFS_ERR_FLAGS, 32'h0000_0000);
      pulse(4'b0001);
      chk("mach exc", 1'b1, machine_exception);
      chk("no err irq", 1'b0, error_irq);
      chk("halted dbl", 1'b1, halted);
      bus(1'b1, `OFS_CONTROL, 32'h0000_0027);
      repeat (3) @(posedge mclk);
      chk("mach exc off", 1'b0, machine_exception);
   endtask
   task automatic s_access();
      logic [7:0] s0;
      s0 = starts;
      len <= 4'h2;
      bus(1'b1, `OFS_CONTROL, 32'h0000_0005);
      flow.restart <= 1'b1;
      wait_idle();
      chk("internal refused", s0, starts);
      bus(1'b1, `OFS_CONTROL, 32'h0000_0006);
      flow.restart <= 1'b0;
      bus(1'b1, `OFS_FLOW, 32'h0000_0004);
      wait_idle();
      chk("bus refused", s0, starts);
      flow.restart <= 1'b1;
      wait_idle();
      chk("internal start", s0 + 8'h01, starts);
   endtask
   task automatic s_rmode();
      logic [7:0] s0;
      s0 = starts;
      flow <= '0;
      bus(1'b1, `OFS_CONV_FLAGS, 32'h0000_FFFF);
      bus(1'b1, `OFS_CONTROL, 32'h0000_0003);
      bus(1'b1, `OFS_FLOW, 32'h0000_0004);
      bus(1'b1, `OFS_FLOW, 32'h0000_0002);
      wait_idle();
      chk("restart mode start", s0 + 8'h01, starts);
      rd_chk("no overrun", `OFS_ERR_FLAGS, 32'h0000_0000);
      flow.restart <= 1'b1;
      @(posedge mclk);
      flow.kick <= 1'b1;
      repeat (3) @(posedge mclk);
      rd_chk("kick overrun", `OFS_ERR_FLAGS, 32'h0000_0008);
      chk("overrun halted", 1'b1, halted);
      flow <= '0;
      bus(1'b1, `OFS_CONTROL, 32'h0000_0023);
   endtask
   task automatic summarize();
      if (n_fail == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      #(25 * 20000);
      n_fail++;
      summarize();
   end
   initial begin
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      s_regs();
      s_list0();
      s_swap();
      s_minor();
      s_abort();
      s_severe();
      s_access();
      s_rmode();
      summarize();
   end
endmodule

//--- dv/conv_engine_model.sv
// Purpose: Conversion engine stand-in at the far side of the flow block
// Assumes: One stored result every three cycles after start_sequence
// Notes: Idle fields toggle so stale values are never mistaken for results
`timescale 1ns/1ps
module conv_engine_model
   import adc_flow_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic start_sequence,
   input wire logic abort_conversion,
   input wire logic [3:0] list_len, // One length for both lists
   output conv_event_s conv_event,
   output logic busy,
   output logic [7:0] starts
);
   logic [3:0] idx;
   logic [1:0] gap;
   logic [2:0] noise;
   logic last;
   assign last = (idx + 4'h1) == list_len;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         busy <= 1'b0;
         idx <= '0;
         gap <= '0;
         noise <= '0;
         starts <= '0;
         conv_event <= '0;
      end else begin
         noise <= noise + 3'h1;
         conv_event <= {1'b0, noise, ~noise[0], noise[1], noise[2]};
         if (start_sequence) begin
            busy <= 1'b1;
            idx <= '0;
            gap <= '0;
            starts <= starts + 8'h01;
         end else if (busy) begin
            gap <= gap + 2'h1;
            if (gap == 2'h2) begin
               gap <= '0;
               idx <= idx + 4'h1;
               conv_event <= {1'b1, idx + 4'h1, last, last};
               // Abort ends after the store in flight
               if (last || abort_conversion) begin
                  busy <= 1'b0;
               end
            end
         end
      end
   end
endmodule

//--- src/adc_flow_consts.svh
// Purpose: Offsets, field positions, encodings and reset values of the list flow block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef ADC_FLOW_CONSTS_SVH
`define ADC_FLOW_CONSTS_SVH

`define OFS_CONTROL 12'h000
`define OFS_FLOW 12'h004
`define OFS_CONV_ENABLE 12'h008
`define OFS_CONV_FLAGS 12'h00C
`define OFS_ERR_ENABLE 12'h010
`define OFS_ERR_FLAGS 12'h014
`define OFS_STATUS 12'h018
`define OFS_IMD_INFO 12'h01C
`define OFS_EOL_INFO 12'h020

// Control register fields
`define CTL_ACCESS_LO 0
`define CTL_CONVERSION_KICK_BIT_MODE 2
`define CTL_CMD_DOUBLE 3
`define CTL_RES_DOUBLE 4
`define CTL_SOFT_RESET 5
`define ACCESS_BUS_ONLY 2'h1
`define ACCESS_INT_ONLY 2'h2
`define ACCESS_BOTH 2'h3
`define CONTROL_RESET 2'h3

// Flow control bits
`define FLW_ABORT 0
`define FLW_KICK 1
`define FLW_RESTART 2
`define FLW_LOAD_OK 3

// Error enable register
`define EEN_ABORT_DONE 0
`define EEN_ERROR 1

// Error flag register
`define ERR_ILLEGAL 0
`define ERR_INVALID_CMD 1
`define ERR_LIST_FAIL 2
`define ERR_CONVERSION_KICK_BIT_OVR 3
`define ERR_DOUBLE_BIT 4
`define ERR_UNEXP_RESTART 5
`define ERR_LOAD_OK 6
`define ERR_CONV_OVF 7
`define ERR_ABORT_DONE 8
`define ERR_WIDTH 9
`define SEVERE_MASK 9'h01F

`endif

//--- src/adc_flow_pkg.sv
// Purpose: Types shared by the list flow block and its bench
// Assumes: Constants live in adc_flow_consts.svh
// Notes: Event structs are one-cycle pulses from the conversion engine, list fetch and memory
package adc_flow_pkg;

   typedef enum logic [2:0] {
      st_need_restart,
      st_wait_kick,
      st_running,
      st_aborting,
      st_halted
   } flow_state_e;

   // Result stored by the conversion engine
   typedef struct packed {
      logic stored;
      logic [3:0] flag_sel;
      logic seq_end;
      logic list_end;
   } conv_event_s;

   // Fault reports from list fetch and memory
   typedef struct packed {
      logic illegal_access;
      logic invalid_command;
      logic list_failure;
      logic double_bit;
   } fault_event_s;

   // Internal flow control levels, acted on at rising edges
   typedef struct packed {
      logic sequence_abort;
      logic kick;
      logic restart;
      logic load_ok;
   } flow_req_s;

endpackage

//--- src/adc_list_flow.sv
// Purpose: Interrupt, list buffering and conversion flow control of a list driven converter
// Assumes: Conversion engine reports stored results as one-cycle pulses; APB slave
// Notes: Soft reset is a self-clearing control bit; it resets flow state, flow bits and indexes and clears severe error flags
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "adc_flow_consts.svh"

// What this block does
// - Conversion, abort-done and error interrupts, each with own enables and flags.
// - Sixteen conversion flags with enables; bit zero marks end of list.
// - Each stored result names which conversion flag it sets.
// - One abort-done flag and enable, set when an abort has completed.
// - Illegal access, invalid command, list failure, trigger overrun halt and raise error.
// - After a severe error the block stays halted until soft reset clears it.
// - Double-bit memory error halts and raises machine exception, not error interrupt.
// - Unexpected restart, load-ok and flag overflow raise error but keep running.
// - Single buffer modes force list selects to zero.
// - Indexes clear at end of list, restart at boundary, and after abort.
// - Double result list switches at first store after list end or abort.
// - End-of-list info names the last result list completely filled.
// - Command lists swap only when load-ok and restart come together.
// - Restart without load-ok keeps command list but still swaps result list.
// - Intermediate info updates whenever flags fifteen to one or end flag set.
// - Last command stored sets end-of-list flag and updates end info.
// - Two-bit field picks bus, internal interface, or both for flow control.
// - Abort, kick, restart and load-ok bits steer flow in two modes.
// - Restart then kick starts conversion from command list zero.
// - Load-ok with restart, then kick, starts from command list one.
// - In trigger mode a finished restart kicks conversion by itself.
// - In restart mode a kick during restart sets trigger overrun.
module adc_list_flow
   import adc_flow_pkg::*;
#(
   parameter int IDX_W = 8
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire conv_event_s conv_event,
   input wire fault_event_s fault_event,
   input wire flow_req_s flow_req,
   output logic start_sequence,
   output logic abort_conversion,
   output logic halted,
   output logic command_list_select,
   output logic result_list_select,
   output logic [IDX_W-1:0] command_index,
   output logic [IDX_W-1:0] result_index,
   output logic conversion_irq,
   output logic abort_done_irq,
   output logic error_irq,
   output logic machine_exception
);

   localparam int INFO_W = IDX_W + 2;

   logic [1:0] flow_access_select;
   logic conversion_kick_bit_mode;
   logic command_list_buffer_mode;
   logic result_list_buffer_mode;
   logic soft_reset;
   logic [15:0] conv_enable;
   logic [1:0] err_enable;
   logic [15:0] conversion_done_flags;
   logic [`ERR_WIDTH-1:0] err_flags;
   logic sequence_abort_bit;
   logic conversion_kick_bit;
   logic restart_bit;
   logic load_ok_bit;
   logic pend_result_swap;
   flow_state_e state;
   flow_req_s req_prev;
   logic [INFO_W-1:0] intermediate_result_info;
   logic [INFO_W-1:0] end_of_list_result_info;

   logic wr_en;
   logic bus_ok;
   logic int_ok;
   logic flow_wr;
   logic req_abort;
   logic req_kick;
   logic req_restart;
   logic req_load_ok;
   logic idle;
   logic restart_done;
   logic abort_done;
   logic stored;
   logic swap_now;
   logic next_rsel;
   logic [15:0] flag_set;
   logic [`ERR_WIDTH-1:0] err_set;
   logic stop_now;

   // APB: one wait-free access phase, pready rises in the first access cycle
   assign wr_en = psel && penable && pready && pwrite;
   assign flow_wr = wr_en && (paddr == `OFS_FLOW);

   assign bus_ok = flow_access_select[0];
   assign int_ok = flow_access_select[1];
   assign req_abort = (int_ok && flow_req.sequence_abort && !req_prev.sequence_abort)
      || (bus_ok && flow_wr && pwdata[`FLW_ABORT]);
   assign req_kick = (int_ok && flow_req.kick && !req_prev.kick)
      || (bus_ok && flow_wr && pwdata[`FLW_KICK]);
   assign req_restart = (int_ok && flow_req.restart && !req_prev.restart)
      || (bus_ok && flow_wr && pwdata[`FLW_RESTART]);
   assign req_load_ok = (int_ok && flow_req.load_ok && !req_prev.load_ok)
      || (bus_ok && flow_wr && pwdata[`FLW_LOAD_OK]);

   assign idle = (state == st_need_restart) || (state == st_wait_kick);
   assign restart_done = idle && restart_bit && !sequence_abort_bit;
   assign stored = conv_event.stored && (state == st_running || state == st_aborting);
   assign abort_done = sequence_abort_bit && (idle || stored);
   assign swap_now = stored && pend_result_swap && result_list_buffer_mode;
   assign next_rsel = swap_now ? !result_list_select : result_list_select;
   assign stop_now = |(err_flags & `SEVERE_MASK);

   // Hardware events that set flags; set wins over a clearing write
   always_comb begin
      flag_set = 16'h0000;
      if (stored && conv_event.flag_sel != 4'h0) begin
         flag_set[conv_event.flag_sel] = 1'b1;
      end
      if (stored && conv_event.list_end && !sequence_abort_bit) begin
         flag_set[0] = 1'b1;
      end
      err_set = '0;
      err_set[`ERR_ILLEGAL] = fault_event.illegal_access;
      err_set[`ERR_INVALID_CMD] = fault_event.invalid_command;
      err_set[`ERR_LIST_FAIL] = fault_event.list_failure;
      err_set[`ERR_CONVERSION_KICK_BIT_OVR] = req_kick && (conversion_kick_bit
         || (restart_bit && !conversion_kick_bit_mode) || (restart_done && conversion_kick_bit_mode));
      err_set[`ERR_DOUBLE_BIT] = fault_event.double_bit;
      err_set[`ERR_UNEXP_RESTART] = req_restart && !restart_bit && !idle
         && !sequence_abort_bit && !req_abort;
      err_set[`ERR_LOAD_OK] = req_load_ok && !req_restart && !restart_bit;
      err_set[`ERR_CONV_OVF] = |(flag_set & conversion_done_flags);
      err_set[`ERR_ABORT_DONE] = abort_done && state != st_halted;
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         req_prev <= '0;
      end else begin
         req_prev <= flow_req;
      end
   end

   // Control and enable registers
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         flow_access_select <= `CONTROL_RESET;
         conversion_kick_bit_mode <= 1'b0;
         command_list_buffer_mode <= 1'b0;
         result_list_buffer_mode <= 1'b0;
         soft_reset <= 1'b0;
         conv_enable <= 16'h0000;
         err_enable <= 2'h0;
      end else begin
         soft_reset <= 1'b0;
         if (wr_en && paddr == `OFS_CONTROL) begin
            flow_access_select <= pwdata[`CTL_ACCESS_LO +: 2];
            conversion_kick_bit_mode <= pwdata[`CTL_CONVERSION_KICK_BIT_MODE];
            command_list_buffer_mode <= pwdata[`CTL_CMD_DOUBLE];
            result_list_buffer_mode <= pwdata[`CTL_RES_DOUBLE];
            soft_reset <= pwdata[`CTL_SOFT_RESET];
         end
         if (wr_en && paddr == `OFS_CONV_ENABLE) begin
            conv_enable <= pwdata[15:0];
         end
         if (wr_en && paddr == `OFS_ERR_ENABLE) begin
            err_enable <= pwdata[1:0];
         end
      end
   end

   // Flags: write one to clear, severe ones only by soft reset
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         conversion_done_flags <= 16'h0000;
         err_flags <= '0;
      end else begin
         if (wr_en && paddr == `OFS_CONV_FLAGS) begin
            conversion_done_flags <= (conversion_done_flags & ~pwdata[15:0]) | flag_set;
         end else begin
            conversion_done_flags <= conversion_done_flags | flag_set;
         end
         if (soft_reset) begin
            err_flags <= (err_flags & ~`SEVERE_MASK) | err_set;
         end else if (wr_en && paddr == `OFS_ERR_FLAGS) begin
            err_flags <= (err_flags & ~(pwdata[`ERR_WIDTH-1:0] & ~`SEVERE_MASK)) | err_set;
         end else begin
            err_flags <= err_flags | err_set;
         end
      end
   end

   // Flow control sequencing
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state <= st_need_restart;
         sequence_abort_bit <= 1'b0;
         conversion_kick_bit <= 1'b0;
         restart_bit <= 1'b0;
         load_ok_bit <= 1'b0;
         pend_result_swap <= 1'b0;
         command_list_select <= 1'b0;
         result_list_select <= 1'b0;
         command_index <= '0;
         result_index <= '0;
         start_sequence <= 1'b0;
      end else if (soft_reset) begin
         state <= st_need_restart;
         sequence_abort_bit <= 1'b0;
         conversion_kick_bit <= 1'b0;
         restart_bit <= 1'b0;
         load_ok_bit <= 1'b0;
         pend_result_swap <= 1'b0;
         command_index <= '0;
         result_index <= '0;
         start_sequence <= 1'b0;
      end else if (stop_now || |(err_set & `SEVERE_MASK)) begin
         state <= st_halted;
         start_sequence <= 1'b0;
      end else begin
         start_sequence <= 1'b0;
         if (req_abort && !sequence_abort_bit) begin
            sequence_abort_bit <= 1'b1;
         end
         if (req_restart && !restart_bit) begin
            restart_bit <= 1'b1;
            load_ok_bit <= req_load_ok;
            if (!idle && !sequence_abort_bit) begin
               sequence_abort_bit <= 1'b1; // Abort issued on behalf of the restart
            end
         end
         if (req_kick) begin
            conversion_kick_bit <= 1'b1;
         end
         if (state == st_running && sequence_abort_bit) begin
            state <= st_aborting;
         end
         if (abort_done) begin
            sequence_abort_bit <= 1'b0;
            command_index <= '0;
            result_index <= '0;
            pend_result_swap <= 1'b1;
            conversion_kick_bit <= 1'b0;
            state <= st_need_restart;
         end else if (restart_done) begin
            restart_bit <= 1'b0;
            load_ok_bit <= 1'b0;
            command_index <= '0;
            result_index <= '0;
            pend_result_swap <= 1'b1;
            if (load_ok_bit && command_list_buffer_mode) begin
               command_list_select <= !command_list_select;
            end
            if (conversion_kick_bit_mode) begin
               conversion_kick_bit <= 1'b1;
            end
            state <= st_wait_kick;
         end else if (state == st_wait_kick && conversion_kick_bit && !restart_bit) begin
            conversion_kick_bit <= 1'b0;
            start_sequence <= 1'b1;
            state <= st_running;
         end else if (stored) begin
            result_list_select <= next_rsel;
            if (swap_now || pend_result_swap) begin
               pend_result_swap <= 1'b0;
            end
            if (conv_event.list_end) begin
               command_index <= '0;
               result_index <= '0;
               pend_result_swap <= 1'b1;
               state <= conversion_kick_bit_mode ? st_wait_kick : st_need_restart;
            end else begin
               command_index <= command_index + 1'b1;
               result_index <= (swap_now ? '0 : result_index) + 1'b1;
               if (conv_event.seq_end) begin
                  state <= st_wait_kick;
               end
            end
         end
         if (!command_list_buffer_mode) begin
            command_list_select <= 1'b0;
         end
         if (!result_list_buffer_mode) begin
            result_list_select <= 1'b0;
         end
      end
   end

   // Result information: list selects and the index of the stored entry
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         intermediate_result_info <= '0;
         end_of_list_result_info <= '0;
      end else if (stored) begin
         if (|flag_set) begin
            intermediate_result_info <= {command_list_select, next_rsel,
               swap_now ? IDX_W'(0) : result_index};
         end
         if (flag_set[0]) begin
            end_of_list_result_info <= {command_list_select, next_rsel,
               swap_now ? IDX_W'(0) : result_index};
         end
      end
   end

   // Interrupt and status outputs, registered
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         conversion_irq <= 1'b0;
         abort_done_irq <= 1'b0;
         error_irq <= 1'b0;
         machine_exception <= 1'b0;
         halted <= 1'b0;
         abort_conversion <= 1'b0;
      end else begin
         conversion_irq <= |(conversion_done_flags & conv_enable);
         abort_done_irq <= err_flags[`ERR_ABORT_DONE] && err_enable[`EEN_ABORT_DONE];
         error_irq <= err_enable[`EEN_ERROR] && (|err_flags[`ERR_CONV_OVF:`ERR_UNEXP_RESTART]
            || |err_flags[`ERR_CONVERSION_KICK_BIT_OVR:`ERR_ILLEGAL]);
         machine_exception <= err_flags[`ERR_DOUBLE_BIT];
         halted <= state == st_halted;
         abort_conversion <= sequence_abort_bit;
      end
   end

   // APB read path and ready, no wait state
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && !penable && !pready;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (psel && !penable) begin
            unique case (paddr)
               `OFS_CONTROL: prdata <= {26'h0, 1'b0, result_list_buffer_mode,
                  command_list_buffer_mode, conversion_kick_bit_mode, flow_access_select};
               `OFS_FLOW: prdata <= {28'h0, load_ok_bit, restart_bit,
                  conversion_kick_bit, sequence_abort_bit};
               `OFS_CONV_ENABLE: prdata <= {16'h0, conv_enable};
               `OFS_CONV_FLAGS: prdata <= {16'h0, conversion_done_flags};
               `OFS_ERR_ENABLE: prdata <= {30'h0, err_enable};
               `OFS_ERR_FLAGS: prdata <= {23'h0, err_flags};
               `OFS_STATUS: prdata <= {8'h0, result_index, command_index, 5'h0,
                  state == st_halted, result_list_select, command_list_select};
               `OFS_IMD_INFO: prdata <= {{(32-INFO_W){1'b0}}, intermediate_result_info};
               `OFS_EOL_INFO: prdata <= {{(32-INFO_W){1'b0}}, end_of_list_result_info};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   severe_halts_a: assert property ((fault_event.illegal_access || fault_event.list_failure)
      && !soft_reset |=> ##1 halted) else $error("severe fault did not halt");
   halt_holds_a: assert property (state == st_halted && !soft_reset |=> state == st_halted)
      else $error("halt left without soft reset");
   dbl_no_error_a: assert property (fault_event.double_bit && err_flags == '0
      && err_set == 9'h010 |=> ##1 machine_exception && !error_irq)
      else $error("double bit error path wrong");
   single_zero_a: assert property (!command_list_buffer_mode && !result_list_buffer_mode
      |=> ##1 !command_list_select && !result_list_select)
      else $error("single buffer select not zero");
   eol_index_a: assert property (stored && conv_event.list_end && !soft_reset && !stop_now
      && err_set == '0 |=> result_index == '0 && command_index == '0)
      else $error("indexes not cleared at end of list");
   swap_cmd_a: assert property (restart_done && !load_ok_bit && !soft_reset && !stop_now
      && err_set == '0 |=> $stable(command_list_select))
      else $error("command list swapped without load ok");
   auto_kick_a: assert property (restart_done && conversion_kick_bit_mode && !soft_reset && !stop_now
      && err_set == '0 |=> conversion_kick_bit ##1 start_sequence)
      else $error("trigger mode restart did not kick");
   kick_overrun_a: assert property (req_kick && restart_bit && !conversion_kick_bit_mode && !soft_reset
      |=> err_flags[`ERR_CONVERSION_KICK_BIT_OVR]) else $error("kick during restart missed");
   irq_follow_a: assert property (|(conversion_done_flags & conv_enable)
      |=> conversion_irq) else $error("conversion interrupt not raised");
   abort_flag_a: assert property (abort_done && state != st_halted
      |=> err_flags[`ERR_ABORT_DONE]) else $error("abort done flag not set");

   list_run_c: cover property (start_sequence ##[1:50] (stored && conv_event.list_end));
   abort_c: cover property (sequence_abort_bit && state == st_aborting ##[1:50] abort_done);
   swap_c: cover property (restart_done && load_ok_bit && command_list_buffer_mode);
   halt_c: cover property (halted ##[1:20] soft_reset);

endmodule
